/* File: include/aidt_pkg.sv */
package aidt_pkg;

    localparam int AIDT_AW = 8;
    localparam int AIDT_CW = 18;

    // Register byte offsets.
    localparam logic [7:0] OFF_CTRL  = 8'h00;
    localparam logic [7:0] OFF_INSTR = 8'h04;
    localparam logic [7:0] OFF_GO    = 8'h08;
    localparam logic [7:0] OFF_STAT  = 8'h0C;
    localparam logic [7:0] OFF_COUNT = 8'h10;
    localparam logic [7:0] OFF_FLAGS = 8'h14;

    localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
    localparam logic [31:0] INSTR_RST = 32'h0000_0000;
    localparam int          GO_BIT    = 0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Opcodes.
    localparam logic [7:0] OP_FIX_SUM  = 8'h37;
    localparam logic [7:0] OP_FIX_DIV  = 8'hD5;
    localparam logic [7:0] OP_FIX_MUL  = 8'hD4;
    localparam logic [7:0] OP_FIX_SUB  = 8'h3F;
    localparam logic [7:0] OP_ADJ_BASE = 8'h0A;
    localparam logic [7:0] OP_PLA      = 8'h63;
    localparam logic [5:0] OP_GRP_HI   = 6'h20;
    localparam logic [2:0] ALU_ADD     = 3'h0;
    localparam logic [2:0] ALU_ADC     = 3'h2;
    localparam logic [2:0] ALU_AND     = 3'h4;

    // Clock counts.
    localparam logic [7:0] T_NONE      = 8'h00;
    localparam logic [7:0] T_ASCII     = 8'h04;
    localparam logic [7:0] T_FIX_MUL   = 8'h10;
    localparam logic [7:0] T_REG       = 8'h01;
    localparam logic [7:0] T_HIT       = 8'h03;
    localparam logic [7:0] T_MISS      = 8'h05;
    localparam logic [7:0] T_PLA_REG   = 8'h06;
    localparam logic [7:0] T_PLA_MEM   = 8'h0A;
    localparam logic [7:0] T_PLA_MISS  = 8'h0A;
    localparam logic [7:0] T_TWO_REG   = 8'h01;
    localparam logic [7:0] T_MISAL     = 8'h02;

    // Flag masks, bit 8 down to 0: overflow, direction, interrupt, trap,
    // sign, zero, auxiliary, parity, carry.
    localparam logic [8:0] FL_ARITH = 9'h11F;
    localparam logic [8:0] FL_SZP   = 9'h01A;
    localparam logic [8:0] FL_OC    = 9'h101;
    localparam logic [8:0] FL_ADJ   = 9'h005;
    localparam logic [8:0] FL_Z     = 9'h008;

    typedef enum logic [3:0] {
        CL_NONE, CL_FIX_SUM, CL_FIX_DIV, CL_FIX_MUL, CL_FIX_SUB,
        CL_ADC, CL_ADD, CL_AND, CL_PLA
    } aidt_class_t;

    typedef struct packed {
        logic [7:0] level;
        logic [7:0] rep;
        logic [9:0] rsvd;
        logic       misal;
        logic       o32;
        logic       a32;
        logic       taken;
        logic       hit;
        logic       prot;
    } aidt_ctrl_t;

    typedef struct packed {
        logic [9:0]  rsvd;
        logic        mem_op;
        logic        sext;
        logic        wide;
        logic        reg_dest;
        logic [2:0]  disp_len;
        logic [2:0]  imm_len;
        logic [3:0]  len;
        aidt_class_t cls;
        logic        known;
        logic        invalid;
        logic        done;
        logic        busy;
    } aidt_stat_t;

    typedef struct packed {
        aidt_class_t cls;
        logic        known;
        logic        invalid;
        logic        mem_op;
        logic        reg_dest;
        logic        wide;
        logic        sext;
        logic [2:0]  imm_len;
        logic [2:0]  disp_len;
        logic [3:0]  len;
        logic [8:0]  fl_mod;
        logic [8:0]  fl_clr;
        logic [7:0]  t_sel;
        logic        two_reg;
        logic        misal_add;
    } aidt_dec_t;

    typedef struct packed {
        logic [7:0] first;
        logic [7:0] second;
        logic [7:0] iter;
        logic [7:0] rep;
        logic [7:0] lvl_cost;
        logic [7:0] level;
        logic       taken;
        logic       two_reg;
        logic       misal;
    } aidt_tim_t;

endpackage : aidt_pkg

/* File: hdl/aidt_clk_calc.sv */
`timescale 1ns/10ps
`default_nettype none
module aidt_clk_calc
    import aidt_pkg::*;
#(
    parameter int CW = AIDT_CW
) (
    input  wire aidt_tim_t     tim,
    output logic [CW-1:0]      total
);

    generate
        if (CW < 18) begin : g_chk
            $error("Count width too narrow for the largest total.");
        end
    endgenerate

    always_comb begin
        total = CW'(tim.taken ? tim.first : tim.second)
              + CW'(tim.rep) * CW'(tim.iter)
              + CW'(tim.level) * CW'(tim.lvl_cost)
              + CW'(tim.two_reg ? T_TWO_REG : T_NONE)
              + CW'(tim.misal ? T_MISAL : T_NONE);
    end

endmodule : aidt_clk_calc
`default_nettype wire

/* File: hdl/aidt_cycle_timer.sv */
`timescale 1ns/10ps
`default_nettype none
module aidt_cycle_timer
    import aidt_pkg::*;
#(
    parameter int CW = AIDT_CW
) (
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic          load,
    input  wire logic [CW-1:0] cycles,
    input  wire logic          stall,
    output logic               busy,
    output logic               done
);

    logic [CW-1:0] remain_r;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            remain_r <= '0;
            busy     <= 1'b0;
            done     <= 1'b0;
        end else if (load) begin
            remain_r <= cycles;
            busy     <= (cycles != '0);
            done     <= (cycles == '0);
        end else if (busy && !stall) begin
            remain_r <= remain_r - CW'(1);
            busy     <= (remain_r != CW'(1));
            done     <= (remain_r == CW'(1));
        end else begin
            done     <= 1'b0;
        end
    end

    a_stall_hold: assert property (@(posedge clk) disable iff (!rstn)
        busy && stall && !load |=> remain_r == $past(remain_r) && busy)
        else $error("Timer advanced during a stall.");

    a_run_end: assert property (@(posedge clk) disable iff (!rstn)
        busy && !stall && !load && remain_r == CW'(1) |=> done && !busy)
        else $error("Timer did not end after its last cycle.");

endmodule : aidt_cycle_timer
`default_nettype wire

/* File: hdl/aidt_decode_top.sv */
`timescale 1ns/10ps
`default_nettype none
module aidt_decode_top
    import aidt_pkg::*;
(
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic [AIDT_AW-1:0] awaddr,
    input  wire logic               awvalid,
    output logic                    awready,
    input  wire logic [31:0]        wdata,
    input  wire logic [3:0]         wstrb,
    input  wire logic               wvalid,
    output logic                    wready,
    output logic [1:0]              bresp,
    output logic                    bvalid,
    input  wire logic               bready,
    input  wire logic [AIDT_AW-1:0] araddr,
    input  wire logic               arvalid,
    output logic                    arready,
    output logic [31:0]             rdata,
    output logic [1:0]              rresp,
    output logic                    rvalid,
    input  wire logic               rready,
    input  wire logic               exec_stall,
    output logic                    exec_busy,
    output logic                    invalid_opcode
);

    aidt_ctrl_t          ctrl_r, ctrl_nxt;
    logic [31:0]         instr_r, instr_nxt;
    logic [AIDT_AW-1:0]  aw_addr_r;
    logic [31:0]         w_data_r;
    logic [3:0]          w_strb_r;
    logic                aw_have_r, w_have_r, wr_fire, go_fire, done_r, tmr_done;
    logic [7:0]          wa, ra, b0, b1, b2;
    aidt_dec_t           dec, dec_r;
    aidt_tim_t           tim;
    aidt_stat_t          stat;
    logic [AIDT_CW-1:0]  total, count_r;
    logic [7:0]          t_hit, t_miss;
    logic [2:0]          alu, md_rm;
    logic [1:0]          md, opn;
    logic                modrm, mem, sib, alu_ok, acc_imm;

    assign wa      = 8'({aw_addr_r[AIDT_AW-1:2], 2'b00});
    assign ra      = 8'({araddr[AIDT_AW-1:2], 2'b00});
    assign wr_fire = aw_have_r && w_have_r && !bvalid;
    assign go_fire = wr_fire && wa == OFF_GO && w_strb_r[0] && w_data_r[GO_BIT] && !exec_busy;
    assign b0      = instr_r[7:0];
    assign b1      = instr_r[15:8];
    assign b2      = instr_r[23:16];
    assign md      = b1[7:6];
    assign md_rm   = b1[2:0];

    // Write address and data are taken independently; the response follows both.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready   <= 1'b1;
            wready    <= 1'b1;
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            aw_addr_r <= '0;
            w_data_r  <= '0;
            w_strb_r  <= '0;
            bvalid    <= 1'b0;
            bresp     <= RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_addr_r <= awaddr;
                aw_have_r <= 1'b1;
                awready   <= 1'b0;
            end
            if (wvalid && wready) begin
                w_data_r <= wdata;
                w_strb_r <= wstrb;
                w_have_r <= 1'b1;
                wready   <= 1'b0;
            end
            if (wr_fire) begin
                aw_have_r <= 1'b0;
                w_have_r  <= 1'b0;
                bvalid    <= 1'b1;
                bresp     <= (wa == OFF_CTRL || wa == OFF_INSTR || wa == OFF_GO)
                             ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    always_comb begin
        ctrl_nxt  = ctrl_r;
        instr_nxt = instr_r;
        for (int i = 0; i < 4; i++) begin
            if (w_strb_r[i]) begin
                ctrl_nxt[8*i +: 8]  = w_data_r[8*i +: 8];
                instr_nxt[8*i +: 8] = w_data_r[8*i +: 8];
            end
        end
        ctrl_nxt.rsvd = '0;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r  <= CTRL_RST;
            instr_r <= INSTR_RST;
        end else if (wr_fire && !exec_busy) begin
            if (wa == OFF_CTRL) begin
                ctrl_r <= ctrl_nxt;
            end
            if (wa == OFF_INSTR) begin
                instr_r <= instr_nxt;
            end
        end
    end

    // Instruction decode of the held bytes.
    always_comb begin
        dec     = '0;
        t_hit   = T_NONE;
        t_miss  = T_NONE;
        alu     = ALU_ADD;
        alu_ok  = 1'b0;
        acc_imm = 1'b0;
        modrm   = 1'b0;
        opn     = 2'd1;
        if (b0 == OP_FIX_SUM || b0 == OP_FIX_SUB) begin
            dec.known  = 1'b1;
            dec.cls    = (b0 == OP_FIX_SUM) ? CL_FIX_SUM : CL_FIX_SUB;
            t_hit      = T_ASCII;
            t_miss     = T_ASCII;
            dec.fl_mod = FL_ADJ;
        end else if ((b0 == OP_FIX_DIV || b0 == OP_FIX_MUL) && b1 == OP_ADJ_BASE) begin
            dec.known  = 1'b1;
            opn        = 2'd2;
            dec.cls    = (b0 == OP_FIX_MUL) ? CL_FIX_MUL : CL_FIX_DIV;
            t_hit      = (b0 == OP_FIX_MUL) ? T_FIX_MUL : T_ASCII;
            t_miss     = t_hit;
            dec.fl_mod = FL_SZP;
        end else if (b0[7:6] == 2'b00 && b0[2:1] != 2'b11
                     && (b0[5:3] == ALU_ADD || b0[5:3] == ALU_ADC || b0[5:3] == ALU_AND)) begin
            alu          = b0[5:3];
            alu_ok       = 1'b1;
            acc_imm      = b0[2];
            modrm        = !b0[2];
            dec.reg_dest = b0[2] | b0[1];
            dec.wide     = b0[0];
            if (b0[2]) begin
                dec.imm_len = b0[0] ? (ctrl_r.o32 ? 3'd4 : 3'd2) : 3'd1;
            end
        end else if (b0[7:2] == OP_GRP_HI
                     && (b1[5:3] == ALU_ADD || b1[5:3] == ALU_ADC || b1[5:3] == ALU_AND)) begin
            alu         = b1[5:3];
            alu_ok      = 1'b1;
            modrm       = 1'b1;
            dec.wide    = b0[0];
            dec.sext    = b0[1];
            dec.imm_len = (b0[0] && !b0[1]) ? (ctrl_r.o32 ? 3'd4 : 3'd2) : 3'd1;
        end else if (b0 == OP_PLA) begin
            dec.known   = 1'b1;
            modrm       = 1'b1;
            dec.cls     = CL_PLA;
            dec.wide    = 1'b1;
            dec.invalid = !ctrl_r.prot;
            dec.fl_mod  = FL_Z;
            if (ctrl_r.prot) begin
                t_hit  = (md == 2'b11) ? T_PLA_REG : T_PLA_MEM;
                t_miss = (md == 2'b11) ? T_PLA_REG : T_PLA_MISS;
            end
        end
        mem = modrm && md != 2'b11;
        sib = mem && ctrl_r.a32 && md_rm == 3'b100;
        if (alu_ok) begin
            dec.known = 1'b1;
            unique case (alu)
                ALU_ADC: dec.cls = CL_ADC;
                ALU_AND: dec.cls = CL_AND;
                default: dec.cls = CL_ADD;
            endcase
            dec.fl_mod = (alu == ALU_AND) ? FL_SZP : FL_ARITH;
            dec.fl_clr = (alu == ALU_AND) ? FL_OC : 9'h000;
            t_hit      = mem ? T_HIT : T_REG;
            t_miss     = mem ? T_MISS : T_REG;
        end
        dec.mem_op = mem;
        if (mem) begin
            if (md == 2'b01) begin
                dec.disp_len = 3'd1;
            end else if (md == 2'b10) begin
                dec.disp_len = ctrl_r.a32 ? 3'd4 : 3'd2;
            end else if (ctrl_r.a32) begin
                dec.disp_len = (md_rm == 3'b101 || (sib && b2[2:0] == 3'b101)) ? 3'd4 : 3'd0;
            end else begin
                dec.disp_len = (md_rm == 3'b110) ? 3'd2 : 3'd0;
            end
        end
        dec.two_reg   = mem && (ctrl_r.a32
                        ? (sib && b2[5:3] != 3'b100 && !(md == 2'b00 && b2[2:0] == 3'b101))
                        : !md_rm[2]);
        dec.misal_add = mem && dec.wide && ctrl_r.o32 && ctrl_r.misal;
        dec.len       = 4'(opn) + 4'(modrm) + 4'(sib) + 4'(dec.disp_len) + 4'(dec.imm_len);
        dec.t_sel     = (dec.invalid || !dec.known) ? T_NONE
                        : (ctrl_r.hit ? t_hit : t_miss);
    end

    always_comb begin
        tim          = '0;
        tim.first    = dec.t_sel;
        tim.second   = dec.t_sel;
        tim.taken    = ctrl_r.taken;
        tim.iter     = T_NONE;
        tim.rep      = ctrl_r.rep;
        tim.lvl_cost = T_NONE;
        tim.level    = ctrl_r.level;
        tim.two_reg  = dec.two_reg && dec.known && !dec.invalid;
        tim.misal    = dec.misal_add && dec.known && !dec.invalid;
    end

    aidt_clk_calc #(.CW(AIDT_CW)) u_calc (
        .tim   (tim),
        .total (total)
    );

    aidt_cycle_timer #(.CW(AIDT_CW)) u_timer (
        .clk    (aclk),
        .rstn   (aresetn),
        .load   (go_fire),
        .cycles (total),
        .stall  (exec_stall),
        .busy   (exec_busy),
        .done   (tmr_done)
    );

    // Launch captures the decode; completion is sticky until a launch clears it, and a done pulse in the same cycle wins over the clear.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dec_r          <= '0;
            count_r        <= '0;
            invalid_opcode <= 1'b0;
            done_r         <= 1'b0;
        end else begin
            if (go_fire) begin
                dec_r          <= dec;
                count_r        <= total;
                invalid_opcode <= dec.invalid;
            end
            if (tmr_done) begin
                done_r <= 1'b1;
            end else if (go_fire) begin
                done_r <= 1'b0;
            end
        end
    end

    always_comb begin
        stat          = '0;
        stat.busy     = exec_busy;
        stat.done     = done_r;
        stat.invalid  = invalid_opcode;
        stat.known    = dec_r.known;
        stat.cls      = dec_r.cls;
        stat.len      = dec_r.len;
        stat.imm_len  = dec_r.imm_len;
        stat.disp_len = dec_r.disp_len;
        stat.reg_dest = dec_r.reg_dest;
        stat.wide     = dec_r.wide;
        stat.sext     = dec_r.sext;
        stat.mem_op   = dec_r.mem_op;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rresp   <= RESP_OKAY;
            case (ra)
                OFF_CTRL:  rdata <= ctrl_r;
                OFF_INSTR: rdata <= instr_r;
                OFF_GO:    rdata <= '0;
                OFF_STAT:  rdata <= stat;
                OFF_COUNT: rdata <= 32'(count_r);
                OFF_FLAGS: rdata <= {7'h00, dec_r.fl_clr, 7'h00, dec_r.fl_mod};
                default: begin
                    rdata <= '0;
                    rresp <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_fix_sum_time: assert property (go_fire && b0 == OP_FIX_SUM
        |=> count_r == AIDT_CW'(T_ASCII) && dec_r.cls == CL_FIX_SUM)
        else $error("Ascii fix after sum count wrong.");
    a_fix_div_time: assert property (go_fire && b0 == OP_FIX_DIV && b1 == OP_ADJ_BASE
        |=> count_r == AIDT_CW'(T_ASCII) && exec_busy)
        else $error("Ascii fix before divide count wrong.");
    a_fix_mul_time: assert property (go_fire && b0 == OP_FIX_MUL && b1 == OP_ADJ_BASE
        |=> count_r == AIDT_CW'(T_FIX_MUL) ##1 exec_busy)
        else $error("Ascii fix after multiply count wrong.");
    a_fix_sub_time: assert property (go_fire && b0 == OP_FIX_SUB
        |=> count_r == AIDT_CW'(T_ASCII) && dec_r.cls == CL_FIX_SUB)
        else $error("Ascii fix after subtract count wrong.");
    a_adc_reg_form: assert property (go_fire && b0[7:2] == 6'h04 && md == 2'b11
        |=> count_r == AIDT_CW'(T_REG) ##1 !exec_busy ##1 done_r)
        else $error("Register form did not finish in one clock.");
    a_adc_mem_form: assert property (go_fire && b0[7:2] == 6'h04 && mem
        && !dec.two_reg && !dec.misal_add
        |=> count_r == AIDT_CW'($past(ctrl_r.hit) ? T_HIT : T_MISS))
        else $error("Memory form hit or miss count wrong.");
    a_imm_group: assert property (go_fire && b0[7:2] == OP_GRP_HI
        && b1[7:3] == 5'h1A |=> count_r == AIDT_CW'(T_REG) && dec_r.cls == CL_ADC)
        else $error("Immediate group register form wrong.");
    a_plain_acc: assert property (go_fire && b0 == 8'h05 && !ctrl_r.o32
        |=> dec_r.cls == CL_ADD && dec_r.len == 4'd3 && count_r == AIDT_CW'(T_REG))
        else $error("Plain sum accumulator form wrong.");
    a_conj_flags: assert property (go_fire && dec.cls == CL_AND
        |=> dec_r.fl_clr == FL_OC && dec_r.fl_mod[8] == 1'b0)
        else $error("Conjunction did not clear overflow and carry.");
    a_priv_prot: assert property (go_fire && b0 == OP_PLA && ctrl_r.prot
        && md == 2'b11 |=> count_r == AIDT_CW'(T_PLA_REG) && !invalid_opcode)
        else $error("Privilege adjust register count wrong.");
    a_priv_real: assert property (go_fire && b0 == OP_PLA && !ctrl_r.prot
        |=> invalid_opcode && !exec_busy ##1 done_r)
        else $error("Real mode privilege adjust not refused.");
    a_route_bits: assert property (go_fire && b0 == 8'h12
        |=> dec_r.reg_dest && !dec_r.wide && dec_r.cls == CL_ADC)
        else $error("Route or size bit decoded wrongly.");

    c_fix_mul: cover property (go_fire && b0 == OP_FIX_MUL ##1 exec_busy[*8]);
    c_priv_real: cover property (go_fire && b0 == OP_PLA && !ctrl_r.prot);
    c_mem_miss: cover property (go_fire && mem && !ctrl_r.hit);
    c_stall_run: cover property (exec_busy && exec_stall ##1 exec_busy);

endmodule : aidt_decode_top
`default_nettype wire

/* File: dv/aidt_stall_model.sv */
`timescale 1ns/10ps
`default_nettype none
module aidt_stall_model (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic en,
    output logic      exec_stall
);
    logic [1:0] ph_r;
    // Holds the timer off one cycle in three, as a wait-stated bus would.
    always_ff @(posedge aclk) begin
        ph_r       <= (!aresetn || ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
        exec_stall <= aresetn && en && ph_r == 2'h2;
    end
endmodule : aidt_stall_model
`default_nettype wire

/* File: dv/test_arith_instr_decode_timing.sv */
`timescale 1ns/10ps
`default_nettype none
module test_arith_instr_decode_timing;
    import aidt_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, sten = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, exec_stall, exec_busy, invalid_opcode;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rv;
    logic [3:0]  wstrb = 4'hF;
    logic [1:0]  bresp, rresp;
    int          n_mismatch = 0, total_checks = 0, nbusy = 0;
    always #25 aclk = ~aclk;
    always @(posedge aclk) if (exec_busy === 1'b1 && exec_stall !== 1'b1) nbusy <= nbusy + 1;
    aidt_decode_top u_aidt_decode_top (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready, .exec_stall, .exec_busy, .invalid_opcode);
    aidt_stall_model u_aidt_stall_model (.aclk, .aresetn, .en(sten), .exec_stall);
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        chk("bresp", {30'h0, bresp}, {30'h0, er});
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] e);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        chk("rresp", {30'h0, rresp}, {30'h0, er});
        chk("rdata", rdata, e);
    endtask : rd
    task automatic run(input logic [31:0] c, input logic [31:0] i, input int n, input logic v);
        wr(OFF_CTRL, c, RESP_OKAY);
        wr(OFF_INSTR, i, RESP_OKAY);
        nbusy <= 0;
        wr(OFF_GO, 32'h1, RESP_OKAY);
        while (exec_busy !== 1'b0) @(posedge aclk);
        @(posedge aclk);
        chk("busy_cycles", 32'(nbusy), 32'(n));
        chk("invalid", {31'h0, invalid_opcode}, {31'h0, v});
        rd(OFF_COUNT, RESP_OKAY, 32'(n));
    endtask : run
    task automatic t_bus;
        rd(OFF_CTRL, RESP_OKAY, CTRL_RST);
        rd(OFF_INSTR, RESP_OKAY, INSTR_RST);
        rd(8'h18, RESP_SLVERR, 32'h0);
        wr(8'h18, 32'hFFFF_FFFF, RESP_SLVERR);
        $display("test bus done");
    endtask : t_bus
    task automatic t_ascii;
        run(32'h0, 32'h37, 4, 1'b0);
        run(32'h1, 32'h3F, 4, 1'b0);
        run(32'h0, 32'h0AD5, 4, 1'b0);
        run(32'h1, 32'h0AD4, 16, 1'b0);
        $display("test ascii done");
    endtask : t_ascii
    task automatic t_alu;
        run(32'h0, 32'hC011, 1, 1'b0);
        run(32'h2, 32'h0711, 3, 1'b0);
        run(32'h1, 32'h0712, 5, 1'b0);
        run(32'h2, 32'h05D083, 1, 1'b0);
        run(32'h0, 32'h0512_5783, 5, 1'b0);
        rd(OFF_STAT, RESP_OKAY, 32'h0038_945A);
        run(32'h3, 32'h0703, 3, 1'b0);
        run(32'h2, 32'h0001, 4, 1'b0);
        run(32'hA, 32'h0018_0401, 4, 1'b0);
        run(32'h0203_0004, 32'h0012_3405, 1, 1'b0);
        run(32'h32, 32'h0711, 5, 1'b0);
        run(32'h0, 32'h1225, 1, 1'b0);
        rd(OFF_FLAGS, RESP_OKAY, {7'h0, FL_OC, 7'h0, FL_SZP});
        $display("test alu done");
    endtask : t_alu
    task automatic t_pla;
        run(32'h1, 32'hC063, 6, 1'b0);
        run(32'h3, 32'h0763, 10, 1'b0);
        run(32'h0, 32'hC063, 0, 1'b1);
        sten <= 1'b1;
        run(32'h0, 32'h0AD4, 16, 1'b0);
        sten <= 1'b0;
        $display("test privilege and stall done");
    endtask : t_pla
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize
    initial begin
        repeat (20000) @(posedge aclk);
        n_mismatch++;
        summarize();
    end
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_bus();
        t_ascii();
        t_alu();
        t_pla();
        summarize();
    end
endmodule : test_arith_instr_decode_timing
`default_nettype wire
